// ==== logic/wwd_pkg.sv ====
// What this block does
// - time base from low or mid oscillator
// - software mode uses software_on_bit, clock select
// - mode 11 always active, even asleep
// - mode 10 active awake, off asleep
// - mode 01 follows software_on_bit only
// - config period 11111 lets prescale_select rule
// - default period after reset is 2 s
// - expiry without valid clear resets device
// - clear outside window is a violation
// - config span 111 lets window field rule
// - window 12.5% to 100% of period
// - five top count bits decide window open
// - violation clears flag; reset sets; software sets
// - count clears on listed events and writes
// - read of control zero arms before clear
// - unarmed clear is a violation unless span is 111 (fully open)
// - in idle, expiry wakes instead of reset
// - idle wake is no interrupt, rate bit untouched
// - expiry in sleep wakes, clears timeout_n
// - code 0 is 1:32, doubling to 10010
// - span 111 fully open, else closed eighths
package wwd_pkg;
    // ----------------------------------------------------------------
    // configuration encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] WWD_MODE_OFF = 2'h0;
    localparam logic [1:0] WWD_MODE_SOFT = 2'h1;
    localparam logic [1:0] WWD_MODE_AWAKE = 2'h2;
    localparam logic [1:0] WWD_MODE_ALWAYS = 2'h3;
    localparam logic [4:0] WWD_PERIOD_SOFT = 5'h1F;
    localparam logic [4:0] WWD_PS_MAX = 5'h12;
    localparam logic [4:0] WWD_PS_MIN = 5'h00;
    localparam logic [4:0] WWD_PS_RESET = 5'h0B;
    localparam logic [2:0] WWD_CS_SOFT = 3'h7;
    localparam logic [2:0] WWD_CS_LOW = 3'h0;
    localparam logic [2:0] WWD_CS_MID = 3'h1;
    localparam logic [2:0] WWD_CS_RESET = 3'h0;
    localparam logic [2:0] WWD_SPAN_SOFT = 3'h7;
    localparam logic [2:0] WWD_SPAN_FULL = 3'h7;
    // ----------------------------------------------------------------
    // control register field positions
    // ----------------------------------------------------------------
    localparam int WWD_C0_SEN_POS = 0;
    localparam int WWD_C0_PS_POS = 1;
    localparam int WWD_C1_WIN_POS = 0;
    localparam int WWD_C1_CS_POS = 4;
    // ----------------------------------------------------------------
    // counter sizing: 1:32 at code zero is 2^5 ticks
    // ----------------------------------------------------------------
    localparam int WWD_BASE_SHIFT = 5;
    localparam int WWD_COUNT_W = 23;
    localparam logic WWD_VIOL_RESET = 1'b1;
endpackage : wwd_pkg

// ==== logic/wwd_windowed_watchdog.sv ====
`timescale 1ns/100ps
module wwd_windowed_watchdog (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic low_freq_osc,
    input wire logic mid_freq_osc,
    input wire logic [1:0] operating_mode_config,
    input wire logic [2:0] config_clock_select,
    input wire logic [4:0] config_period_select,
    input wire logic [2:0] config_open_span_select,
    input wire logic ctrl_zero_wr,
    input wire logic [5:0] ctrl_zero_wdata,
    input wire logic ctrl_zero_rd,
    input wire logic ctrl_one_wr,
    input wire logic [6:0] ctrl_one_wdata,
    input wire logic watchdog_clear_instr,
    input wire logic sleep_enter,
    input wire logic in_sleep,
    input wire logic in_idle,
    input wire logic wake_by_irq,
    input wire logic oscillator_startup_timer,
    input wire logic violation_flag_set,
    output logic [5:0] watchdog_control_zero,
    output logic [6:0] watchdog_control_one,
    output logic [wwd_pkg::WWD_COUNT_W-1:0] watchdog_count_reg,
    output logic watchdog_active,
    output logic watchdog_armed,
    output logic violation_flag,
    output logic timeout_n,
    output logic powerdown_n,
    output logic watchdog_reset_req,
    output logic watchdog_wake_req
);
    import wwd_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] low_sync;
        logic [1:0] mid_sync;
        logic low_prev;
        logic mid_prev;
        logic init_done;
        logic software_on_bit;
        logic [4:0] ps;
        logic [2:0] cs;
        logic [2:0] win;
        logic [WWD_COUNT_W-1:0] count;
        logic active;
        logic armed;
        logic viol;
        logic to_n;
        logic pd_n;
        logic rst_req;
        logic wake_req;
    } wwd_state_t;

    wwd_state_t state;
    wwd_state_t next_state;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // reserved prescale codes fall back to the shortest interval
    function automatic logic [4:0] wwd_legal_ps(input logic [4:0] code);
        if (code > WWD_PS_MAX) begin
            wwd_legal_ps = WWD_PS_MIN;
        end else begin
            wwd_legal_ps = code;
        end
    endfunction : wwd_legal_ps

    // terminal tick count of one period: 2^(5+ps) - 1
    function automatic logic [WWD_COUNT_W-1:0] wwd_last(input logic [4:0] code);
        logic [WWD_COUNT_W:0] one_hot;
        one_hot = '0;
        one_hot[WWD_BASE_SHIFT + int'(code)] = 1'b1;
        wwd_last = one_hot[WWD_COUNT_W-1:0] - {{(WWD_COUNT_W-1){1'b0}}, 1'b1};
    endfunction : wwd_last

    // ----------------------------------------------------------------
    // effective configuration
    // ----------------------------------------------------------------
    logic [4:0] eff_ps;
    logic [2:0] eff_win;
    logic windowed;
    logic [4:0] top_five;
    logic [4:0] open_from;
    logic window_open;
    logic tick;
    logic [WWD_COUNT_W-1:0] last_count;
    logic enable_now;

    // config straps override the software fields unless set to all ones
    always_comb begin
        eff_ps = wwd_legal_ps((config_period_select == WWD_PERIOD_SOFT) ? state.ps
                                                                       : config_period_select);
        eff_win = (config_open_span_select == WWD_SPAN_SOFT) ? state.win
                                                            : config_open_span_select;
        windowed = (eff_win != WWD_SPAN_FULL);
        last_count = wwd_last(eff_ps);
        // count holds 5+ps bits, so shifting by ps leaves its top five
        top_five = 5'(state.count >> eff_ps);
        // closed eighths = 7 - code, in units of 1/32 of the period
        open_from = {3'(WWD_SPAN_FULL - eff_win), 2'h0};
        window_open = (top_five >= open_from);
    end

    // time base from the selected oscillator, edges of synced copies
    always_comb begin
        if (state.cs == WWD_CS_MID) begin
            tick = state.mid_sync[1] && !state.mid_prev;
        end else begin
            tick = state.low_sync[1] && !state.low_prev;
        end
    end

    // operating mode table
    always_comb begin
        unique case (operating_mode_config)
            WWD_MODE_ALWAYS: enable_now = 1'b1;
            WWD_MODE_AWAKE: enable_now = !in_sleep;
            WWD_MODE_SOFT: enable_now = state.software_on_bit;
            WWD_MODE_OFF: enable_now = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic clear_ok;
    logic violation;
    logic expiry;
    logic halted;
    logic count_clear;

    always_comb begin
        next_state = state;
        // pins cross domains through two flops before any use
        next_state.low_sync = {state.low_sync[0], low_freq_osc};
        next_state.mid_sync = {state.mid_sync[0], mid_freq_osc};
        next_state.low_prev = state.low_sync[1];
        next_state.mid_prev = state.mid_sync[1];
        next_state.rst_req = 1'b0;
        next_state.wake_req = 1'b0;
        next_state.active = enable_now;

        // straps are caught once after reset release, never in reset
        next_state.init_done = 1'b1;
        if (!state.init_done) begin
            next_state.ps = (config_period_select == WWD_PERIOD_SOFT) ? WWD_PS_RESET
                                                                      : config_period_select;
            next_state.cs = (config_clock_select == WWD_CS_SOFT) ? WWD_CS_RESET : config_clock_select;
            next_state.win = config_open_span_select;
        end

        // register writes; strap-owned fields stay read-only
        if (ctrl_zero_wr) begin
            next_state.software_on_bit = ctrl_zero_wdata[WWD_C0_SEN_POS];
            if (config_period_select == WWD_PERIOD_SOFT) begin
                next_state.ps = ctrl_zero_wdata[WWD_C0_PS_POS +: 5];
            end
        end
        if (ctrl_one_wr) begin
            if (config_clock_select == WWD_CS_SOFT) begin
                next_state.cs = ctrl_one_wdata[WWD_C1_CS_POS +: 3];
            end
            if (config_open_span_select == WWD_SPAN_SOFT) begin
                next_state.win = ctrl_one_wdata[WWD_C1_WIN_POS +: 3];
            end
        end

        // a read of control zero arms; a clear instruction while enabled disarms
        if (ctrl_zero_rd) begin
            next_state.armed = 1'b1;
        end
        clear_ok = 1'b0;
        violation = 1'b0;
        if (watchdog_clear_instr && enable_now) begin
            next_state.armed = 1'b0;
            if (!windowed) begin
                clear_ok = 1'b1;
            end else if (state.armed && window_open) begin
                clear_ok = 1'b1;
            end else begin
                violation = 1'b1;
            end
        end

        expiry = enable_now && tick && (state.count >= last_count) && !clear_ok;
        halted = in_sleep || in_idle;

        // a halted core cannot be reset by expiry: wake it instead
        if (expiry && halted) begin
            next_state.wake_req = 1'b1;
        end else if (expiry || violation) begin
            next_state.rst_req = 1'b1;
        end
        if (expiry) begin
            next_state.to_n = 1'b0;
        end
        if (sleep_enter) begin
            next_state.to_n = 1'b1;
            next_state.pd_n = 1'b0;
        end

        // the hardware clear outranks a same-cycle software set
        if (violation) begin
            next_state.viol = 1'b0;
        end else if (violation_flag_set) begin
            next_state.viol = 1'b1;
        end

        // all clearing causes in one place
        count_clear = !enable_now || clear_ok || sleep_enter || wake_by_irq
                      || oscillator_startup_timer || ctrl_zero_wr || ctrl_one_wr || expiry
                      || !state.init_done;
        if (count_clear) begin
            next_state.count = '0;
        end else if (tick) begin
            next_state.count = state.count + {{(WWD_COUNT_W-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // only constants under reset; the flag starts set as after power-up
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.ps <= WWD_PS_RESET;
            state.cs <= WWD_CS_RESET;
            state.win <= WWD_SPAN_FULL;
            state.viol <= WWD_VIOL_RESET;
            state.to_n <= 1'b1;
            state.pd_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    // the wake pulse is not an interrupt; no rate or recover bit is touched
    assign watchdog_control_zero = {state.ps, state.software_on_bit};
    assign watchdog_control_one = {state.cs, 1'b0, state.win};
    assign watchdog_count_reg = state.count;
    assign watchdog_active = state.active;
    assign watchdog_armed = state.armed;
    assign violation_flag = state.viol;
    assign timeout_n = state.to_n;
    assign powerdown_n = state.pd_n;
    assign watchdog_reset_req = state.rst_req;
    assign watchdog_wake_req = state.wake_req;
endmodule : wwd_windowed_watchdog

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import wwd_pkg::*;
    logic clk_sys = 1'h0, rst_n = 1'h0;
    logic low_freq_osc, mid_freq_osc, ctrl_zero_rd, watchdog_clear_instr;
    logic [1:0] operating_mode_config = 2'h3;
    logic [2:0] config_clock_select = 3'h7, config_open_span_select = 3'h7;
    logic [4:0] config_period_select = 5'h1F;
    logic ctrl_zero_wr = 1'h0, ctrl_one_wr = 1'h0, sleep_enter = 1'h0, in_sleep = 1'h0, in_idle = 1'h0;
    logic wake_by_irq = 1'h0, oscillator_startup_timer = 1'h0, violation_flag_set = 1'h0;
    logic [5:0] ctrl_zero_wdata = 6'h00, watchdog_control_zero;
    logic [6:0] ctrl_one_wdata = 7'h00, watchdog_control_one;
    logic [WWD_COUNT_W-1:0] watchdog_count_reg;
    logic watchdog_active, watchdog_armed, violation_flag, timeout_n, powerdown_n;
    logic watchdog_reset_req, watchdog_wake_req;
    int miscompares = 0, n_checks = 0;
    wwd_windowed_watchdog wwd_windowed_watchdog_i (.*);
    wwd_core_model wwd_core_model_i (.*);
    initial forever #12.5 clk_sys = ~clk_sys;
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic tick(int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask : tick
    task automatic chk(logic [22:0] got, logic [22:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1'h1;
        tick(1);
        s = 1'h0;
    endtask : pulse
    task automatic wr0(logic [5:0] d);
        ctrl_zero_wdata = d;
        pulse(ctrl_zero_wr);
    endtask : wr0
    task automatic wr1(logic [6:0] d);
        ctrl_one_wdata = d;
        pulse(ctrl_one_wr);
    endtask : wr1
    // bounded wait on a request pulse or on the count reaching v
    task automatic wait_for(int v, output int k);
        k = 0;
        while (v < 0 ? watchdog_reset_req !== 1'h1 && watchdog_wake_req !== 1'h1 : watchdog_count_reg < v) begin
            if (k == 400) begin
                miscompares++;
                $display("MISMATCH t=%0t wait timed out", $time);
                print_verdict();
            end
            tick(1);
            k++;
        end
    endtask : wait_for
    task automatic print_verdict();
        $display("TB: checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        chk(watchdog_control_zero, {5'h0B, 1'h0});
        chk(watchdog_control_one, 7'h07);
        chk(violation_flag, 1'h1);
        $display("test reset done");
    endtask : test_reset
    // every mode against software bit and sleep state
    task automatic test_modes();
        for (int i = 0; i < 16; i++) begin
            operating_mode_config = i[1:0];
            in_sleep = i[2];
            wr0({5'h00, i[3]});
            tick(3);
            chk(watchdog_active, i[1:0] == 3 || (i[1:0] == 2 && !i[2])
                || (i[1:0] == 1 && i[3]));
        end
        in_sleep = 1'h0;
        $display("test modes done");
    endtask : test_modes
    // expiry awake, idle and asleep; period 32 ticks of 4 clocks
    task automatic test_expiry();
        int k;
        operating_mode_config = WWD_MODE_ALWAYS;
        for (int j = 0; j < 3; j++) begin
            in_idle = j == 1;
            in_sleep = j == 2;
            wr0(6'h01);
            wait_for(-1, k);
            chk(watchdog_reset_req, j == 0);
            chk(watchdog_wake_req, j != 0);
            chk(k >= 120 && k <= 136, 1'h1);
            tick(1);
            chk(timeout_n, 1'h0);
        end
        in_idle = 1'h0;
        in_sleep = 1'h0;
        // period strap owns the period; the field write is then refused
        config_period_select = 5'h01;
        tick(1);
        wr0(6'h03);
        chk(watchdog_control_zero, 6'h01);
        wait_for(-1, k);
        chk(k >= 248 && k <= 264, 1'h1);
        config_period_select = 5'h1F;
        // mid oscillator ticks every 6 clocks instead of 4
        wr1(7'h17);
        chk(watchdog_control_one, 7'h17);
        wait_for(-1, k);
        chk(k >= 184 && k <= 200, 1'h1);
        $display("test expiry done");
    endtask : test_expiry
    // window code 3: closed below count 16
    task automatic test_window();
        int k;
        wr1(7'h03);
        chk(watchdog_control_one, 7'h03);
        wwd_core_model_i.arm();
        wwd_core_model_i.clr();
        chk(watchdog_reset_req, 1'h1);
        chk(violation_flag, 1'h0);
        pulse(violation_flag_set);
        chk(violation_flag, 1'h1);
        wr1(7'h03);
        wait_for(18, k);
        wwd_core_model_i.clr();
        chk(watchdog_reset_req, 1'h1);
        wr1(7'h03);
        wait_for(18, k);
        wwd_core_model_i.arm();
        wwd_core_model_i.clr();
        chk(watchdog_reset_req, 1'h0);
        chk(watchdog_count_reg, 23'h0);
        chk(watchdog_armed, 1'h0);
        $display("test window done");
    endtask : test_window
    task automatic test_clears();
        wr1(7'h07);
        // span strap overrides the full-open field: early clear violates
        config_open_span_select = 3'h0;
        wwd_core_model_i.clr();
        chk(watchdog_reset_req, 1'h1);
        config_open_span_select = 3'h7;
        tick(20);
        pulse(sleep_enter);
        chk(watchdog_count_reg, 23'h0);
        chk(powerdown_n, 1'h0);
        tick(20);
        pulse(wake_by_irq);
        chk(watchdog_count_reg, 23'h0);
        tick(20);
        pulse(oscillator_startup_timer);
        chk(watchdog_count_reg, 23'h0);
        tick(20);
        operating_mode_config = WWD_MODE_OFF;
        tick(3);
        chk(watchdog_count_reg, 23'h0);
        $display("test clears done");
    endtask : test_clears
    initial begin
        repeat (6) @(posedge clk_sys);
        #2 rst_n = 1'h1;
        tick(2);
        test_reset();
        test_modes();
        test_expiry();
        test_window();
        test_clears();
        print_verdict();
    end
endmodule : testbench

// ==== sim/wwd_asserts.sv ====
`timescale 1ns/100ps
module wwd_asserts import wwd_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] operating_mode_config,
    input wire logic [2:0] config_open_span_select,
    input wire logic ctrl_zero_wr,
    input wire logic ctrl_zero_rd,
    input wire logic ctrl_one_wr,
    input wire logic watchdog_clear_instr,
    input wire logic sleep_enter,
    input wire logic in_sleep,
    input wire logic in_idle,
    input wire logic wake_by_irq,
    input wire logic oscillator_startup_timer,
    input wire logic violation_flag_set,
    input wire logic [6:0] watchdog_control_one,
    input wire logic [WWD_COUNT_W-1:0] watchdog_count_reg,
    input wire logic watchdog_active,
    input wire logic watchdog_armed,
    input wire logic violation_flag,
    input wire logic timeout_n,
    input wire logic powerdown_n,
    input wire logic watchdog_reset_req,
    input wire logic watchdog_wake_req
);
    // ----------------------------------------------------------------
    // checks on the core-facing side
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // win_on covers only a software-owned span field below 111; a span strap below 111 also windows
    wire logic win_on = config_open_span_select == WWD_SPAN_SOFT && watchdog_control_one[2:0] != WWD_SPAN_FULL;
    wire logic clr_evt = ctrl_zero_wr || ctrl_one_wr || oscillator_startup_timer || sleep_enter || wake_by_irq;
    sequence arm_clr;
        ctrl_zero_rd && watchdog_active ##1 watchdog_clear_instr && watchdog_armed;
    endsequence
    reset_pulse_a: assert property (watchdog_reset_req |=> !watchdog_reset_req)
        else $error("reset pulse too long");
    wake_cause_a: assert property (watchdog_wake_req |-> $past(in_idle || in_sleep))
        else $error("wake while awake");
    idle_block_a: assert property (in_idle && $past(in_idle) |-> !watchdog_reset_req)
        else $error("reset in idle");
    mode_off_a: assert property ($past(operating_mode_config == WWD_MODE_OFF) |-> !watchdog_active)
        else $error("on in off mode");
    always_on_a: assert property ((operating_mode_config == WWD_MODE_ALWAYS) [*3] |-> watchdog_active)
        else $error("off in mode 11");
    unarmed_clr_a: assert property (watchdog_clear_instr && !watchdog_armed && watchdog_active
        && win_on && !in_idle && !in_sleep && !ctrl_zero_rd |=> watchdog_reset_req && !violation_flag)
        else $error("unarmed clear kept");
    count_clear_a: assert property (clr_evt |=> watchdog_count_reg == '0)
        else $error("count not cleared");
    sleep_status_a: assert property (sleep_enter |=> !powerdown_n && timeout_n)
        else $error("sleep status bits");
    flag_set_a: assert property (violation_flag_set && !watchdog_clear_instr |=> violation_flag)
        else $error("flag not set");
    arm_read_a: assert property (ctrl_zero_rd && watchdog_active
        && !watchdog_clear_instr |=> watchdog_armed) else $error("no arm");
    clr_disarm_a: assert property (arm_clr |=> !watchdog_armed)
        else $error("arm kept after clear");
endmodule : wwd_asserts
bind wwd_windowed_watchdog wwd_asserts wwd_asserts_i (.*);

// ==== sim/wwd_core_model.sv ====
`timescale 1ns/100ps
module wwd_core_model (
    input wire logic clk_sys,
    output logic low_freq_osc,
    output logic mid_freq_osc,
    output logic ctrl_zero_rd,
    output logic watchdog_clear_instr
);
    int unsigned n;
    initial begin
        n = 0;
        low_freq_osc = 1'h0;
        mid_freq_osc = 1'h0;
        ctrl_zero_rd = 1'h0;
        watchdog_clear_instr = 1'h0;
    end
    // scaled time bases, far faster than real so a period fits a short run
    always @(posedge clk_sys) begin
        n <= n + 1;
        low_freq_osc <= n[1];
        mid_freq_osc <= (n % 6) < 3;
    end
    // arming read, one cycle, caller sits just after an edge
    task automatic arm();
        ctrl_zero_rd = 1'h1;
        @(posedge clk_sys);
        #2 ctrl_zero_rd = 1'h0;
    endtask : arm
    // clear instruction, one cycle
    task automatic clr();
        watchdog_clear_instr = 1'h1;
        @(posedge clk_sys);
        #2 watchdog_clear_instr = 1'h0;
    endtask : clr
endmodule : wwd_core_model
